// >>> hdl/tsb_pkg.sv
// package: batch delay sequencer constants and types
package tsb_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int MS_PER_UNIT = 1;
    localparam int CYC_PER_MS = CLK_HZ / 1000 * MS_PER_UNIT;
    localparam logic [3:0] FN_XYZ = 4'h0;
    localparam logic [3:0] FN_XY = 4'h1;
    localparam logic [6:0] BD_1 = 7'h01;
    localparam logic [6:0] BD_2 = 7'h02;
    localparam logic [6:0] BD_4 = 7'h04;
    localparam logic [6:0] BD_10 = 7'h0A;
    localparam logic [6:0] BD_20 = 7'h14;
    localparam logic [6:0] BD_40 = 7'h28;
    localparam logic [6:0] BD_100 = 7'h64;
    localparam int SET_W = 16;
    typedef struct packed {
        logic scan_xy;
        logic [SET_W-1:0] sample_count;
    } tsb_set_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CONV = 3'h2,
        ST_WAIT = 3'h4
    } tsb_state_t;
endpackage

// >>> hdl/tsb_fifo.sv
// file: parameterised valid/ready fifo
`timescale 1ns/1ns
module tsb_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic do_wr;
    logic do_rd;
    assign o_ready = cnt != (AW+1)'(DEPTH);
    assign o_valid = cnt != '0;
    assign o_data = mem[rp];
    assign do_wr = i_valid && o_ready;
    assign do_rd = o_valid && i_ready;
    always_ff @(posedge i_clk)
    begin
        if (do_wr)
        begin
            mem[wp] <= i_data;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wp <= wp + 1'b1;
            end
            if (do_rd)
            begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// >>> hdl/tsb_top.sv
// file: touch scan batch delay sequencer
`timescale 1ns/1ns
module tsb_top #(
    parameter int CYC_MS = tsb_pkg::CYC_PER_MS,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pen_touch,
    input wire logic i_pen_scan_mode_select,
    input wire logic [3:0] i_converter_function,
    input wire logic i_function_write,
    input wire logic i_stop,
    input wire logic [2:0] i_batch_delay_select,
    input wire logic [15:0] i_conv_cycles,
    input wire logic i_out_ready,
    output logic o_scan_start,
    output logic o_busy,
    output logic o_waiting,
    output logic o_set_valid,
    output logic [tsb_pkg::SET_W:0] o_set_data,
    output logic o_fifo_ready
);
    localparam int W = tsb_pkg::SET_W + 1;
    tsb_pkg::tsb_state_t state;
    logic scan_fn;
    logic engaged;
    logic [6:0] delay_ms;
    logic [31:0] ms_cnt;
    logic [6:0] ms_left;
    logic [15:0] conv_cnt;
    logic [15:0] set_count;
    logic push;
    logic fifo_rdy;
    logic f_valid;
    logic [W-1:0] f_data;
    tsb_pkg::tsb_set_t set_word;
    logic delay_done;
    logic start_now;

    assign scan_fn = i_converter_function == tsb_pkg::FN_XYZ
        || i_converter_function == tsb_pkg::FN_XY;
    // decode of delay select to milliseconds
    always_comb
    begin
        case (i_batch_delay_select)
            3'h1: delay_ms = tsb_pkg::BD_1;
            3'h2: delay_ms = tsb_pkg::BD_2;
            3'h3: delay_ms = tsb_pkg::BD_4;
            3'h4: delay_ms = tsb_pkg::BD_10;
            3'h5: delay_ms = tsb_pkg::BD_20;
            3'h6: delay_ms = tsb_pkg::BD_40;
            3'h7: delay_ms = tsb_pkg::BD_100;
            default: delay_ms = 7'h00;
        endcase
    end
    // host mode engages on function write after pen detect
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !i_pen_touch || i_stop)
        begin
            engaged <= 1'b0;
        end
        else if (i_pen_scan_mode_select && scan_fn)
        begin
            engaged <= 1'b1;
        end
        else if (!i_pen_scan_mode_select && scan_fn && i_function_write)
        begin
            engaged <= 1'b1;
        end
    end
    assign delay_done = ms_left == 7'h00;
    assign start_now = engaged && i_pen_touch && !i_stop && fifo_rdy;
    // scan sequencer
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || i_stop || !i_pen_touch)
        begin
            state <= tsb_pkg::ST_IDLE;
        end
        else
        begin
            case (state)
                tsb_pkg::ST_IDLE:
                begin
                    if (start_now)
                    begin
                        state <= tsb_pkg::ST_CONV;
                    end
                end
                tsb_pkg::ST_CONV:
                begin
                    if (conv_cnt <= 16'h0001)
                    begin
                        state <= tsb_pkg::ST_WAIT;
                    end
                end
                tsb_pkg::ST_WAIT:
                begin
                    if (delay_done && start_now)
                    begin
                        state <= tsb_pkg::ST_CONV;
                    end
                end
                default: state <= tsb_pkg::ST_IDLE;
            endcase
        end
    end
    logic go;
    assign go = (state == tsb_pkg::ST_IDLE && start_now)
        || (state == tsb_pkg::ST_WAIT && delay_done && start_now);
    // conversion time counter
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            conv_cnt <= '0;
        end
        else if (go)
        begin
            conv_cnt <= i_conv_cycles;
        end
        else if (conv_cnt != '0)
        begin
            conv_cnt <= conv_cnt - 1'b1;
        end
    end
    // millisecond batch delay timer
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ms_left <= '0;
            ms_cnt <= '0;
        end
        else if (go)
        begin
            ms_left <= delay_ms;
            ms_cnt <= '0;
        end
        else if (ms_left != '0)
        begin
            if (ms_cnt == 32'(CYC_MS - 1))
            begin
                ms_cnt <= '0;
                ms_left <= ms_left - 1'b1;
            end
            else
            begin
                ms_cnt <= ms_cnt + 1'b1;
            end
        end
    end
    // processed set record into fifo, written at conversion end
    assign push = state == tsb_pkg::ST_CONV && conv_cnt <= 16'h0001
        && i_pen_touch && !i_stop;
    always_comb
    begin
        set_word.scan_xy = i_converter_function == tsb_pkg::FN_XY;
        set_word.sample_count = set_count;
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            set_count <= '0;
        end
        else if (state == tsb_pkg::ST_CONV && conv_cnt <= 16'h0001)
        begin
            set_count <= set_count + 1'b1;
        end
    end
    tsb_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(push),
        .o_ready(fifo_rdy),
        .i_data(set_word),
        .o_valid(f_valid),
        .i_ready(i_out_ready && !o_set_valid),
        .o_data(f_data)
    );
    // registered outputs
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_scan_start <= 1'b0;
            o_busy <= 1'b0;
            o_waiting <= 1'b0;
            o_set_valid <= 1'b0;
            o_set_data <= '0;
            o_fifo_ready <= 1'b0;
        end
        else
        begin
            o_scan_start <= go;
            o_busy <= state == tsb_pkg::ST_CONV;
            o_waiting <= state == tsb_pkg::ST_WAIT;
            o_fifo_ready <= fifo_rdy;
            if (o_set_valid)
            begin
                o_set_valid <= 1'b0;
            end
            else if (f_valid && i_out_ready)
            begin
                o_set_valid <= 1'b1;
                o_set_data <= f_data;
            end
        end
    end

    stop_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_stop || !i_pen_touch) |=> state == tsb_pkg::ST_IDLE)
        else $error("scan not stopped");
    no_early_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_WAIT && ms_left != '0) |=> state != tsb_pkg::ST_CONV)
        else $error("set started before delay expiry");
    timer_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        go |=> ms_left == $past(delay_ms))
        else $error("delay timer not loaded at scan start");
    zero_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_batch_delay_select == 3'h0 && go) |=> delay_done)
        else $error("zero delay inserted wait");
    host_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!engaged && !i_pen_scan_mode_select && !i_function_write) |=> !engaged)
        else $error("host scan engaged without write");
    self_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_IDLE && engaged && i_pen_touch && !i_stop && fifo_rdy)
        |=> state == tsb_pkg::ST_CONV)
        else $error("pen touch did not start scan");
    conv_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        go |=> conv_cnt == $past(i_conv_cycles))
        else $error("conversion time not loaded");
    retrig_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_WAIT && delay_done && start_now)
        |=> state == tsb_pkg::ST_CONV && o_scan_start)
        else $error("no retrigger at expiry");

    // flag, timer, record, state and engagement checks
    busy_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_busy == ($past(state) == tsb_pkg::ST_CONV))
        else $error("busy flag does not follow conversion");
    wait_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_waiting == ($past(state) == tsb_pkg::ST_WAIT))
        else $error("waiting flag does not follow wait");
    start_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_scan_start == $past(go))
        else $error("scan start flag does not follow start");
    conv_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_CONV && conv_cnt > 16'h0001 && i_pen_touch && !i_stop)
        |=> state == tsb_pkg::ST_CONV)
        else $error("conversion cut short");
    wait_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_WAIT && !delay_done && i_pen_touch && !i_stop)
        |=> state == tsb_pkg::ST_WAIT)
        else $error("wait left before delay expiry");
    ms_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!go && ms_left != 7'h00 && ms_cnt == 32'(CYC_MS - 1))
        |=> ms_left == $past(ms_left) - 7'h01)
        else $error("millisecond step missed");
    ms_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!go && ms_left == 7'h00) |=> ms_left == 7'h00)
        else $error("expired delay timer moved");
    push_room_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        push |-> fifo_rdy)
        else $error("set record lost on full fifo");
    valid_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_set_valid |=> !o_set_valid)
        else $error("record valid longer than one cycle");
    host_engage_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_pen_scan_mode_select && scan_fn && i_function_write && i_pen_touch && !i_stop)
        |=> engaged)
        else $error("host write did not engage scan");
    self_engage_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_pen_scan_mode_select && scan_fn && i_pen_touch && !i_stop) |=> engaged)
        else $error("self mode did not engage on touch");
    code_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!engaged && !scan_fn) |=> !engaged)
        else $error("scan engaged with non scan code");
    pen_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_pen_touch || i_stop) |=> !engaged)
        else $error("engagement kept after touch loss");
    longest_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_batch_delay_select == 3'h7 && go) |=> ms_left == tsb_pkg::BD_100)
        else $error("longest delay code misdecoded");
    shortest_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_batch_delay_select == 3'h1 && go) |=> ms_left == tsb_pkg::BD_1)
        else $error("shortest delay code misdecoded");
    start_conv_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        go |=> state == tsb_pkg::ST_CONV)
        else $error("set start did not convert");
    idle_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_IDLE) |=> !o_busy && !o_waiting)
        else $error("flags raised while idle");
    full_stall_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !fifo_rdy |-> !go)
        else $error("set started on full fifo");
    idle_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == tsb_pkg::ST_IDLE && !engaged) |-> !go)
        else $error("set started without engagement");
endmodule

// >>> test/tsb_host_model.sv
// host side model: set record sink with periodic stalls
`timescale 1ns/1ns
module tsb_host_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hold,
    input wire logic i_set_valid,
    input wire logic [16:0] i_set_data,
    output logic o_out_ready,
    output int o_records,
    output logic o_last_xy,
    output int o_steps
);
    logic [1:0] ph;
    logic [15:0] last_idx;
    // not ready one cycle in four, or whole time on hold
    assign o_out_ready = !i_hold && (ph != 2'h3);
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ph <= 2'h0;
            o_records <= 0;
            o_last_xy <= 1'b0;
            o_steps <= 0;
            last_idx <= '0;
        end
        else
        begin
            ph <= ph + 2'h1;
            if (i_set_valid)
            begin
                o_records <= o_records + 1;
                o_last_xy <= i_set_data[16];
                last_idx <= i_set_data[15:0];
                if (i_set_data[15:0] == last_idx + 16'h0001)
                    o_steps <= o_steps + 1;
            end
        end
    end
endmodule

// >>> test/tsb_top_tb.sv
// testbench for the touch scan batch delay sequencer
`timescale 1ns/1ns
module tsb_top_tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic pen = 1'b0;
    logic pen_scan_mode_select = 1'b0;
    logic fw = 1'b0;
    logic stp = 1'b0;
    logic hold = 1'b0;
    logic [3:0] fn = 4'h0;
    logic [2:0] bd = 3'h0;
    logic [15:0] cc = 16'h0003;
    logic rdy, st, bsy, wt, sv, frd, lxy;
    logic [16:0] sd;
    int miscompares = 0;
    int checks_done = 0;
    int n, recs;
    int dly[8] = '{0, 1, 2, 4, 10, 20, 40, 100};
    localparam int CYC = 10;
    int r0, s0, stps;

    tsb_top #(.CYC_MS(CYC), .DEPTH(16)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_pen_touch(pen), .i_pen_scan_mode_select(pen_scan_mode_select), .i_converter_function(fn),
        .i_function_write(fw), .i_stop(stp), .i_batch_delay_select(bd),
        .i_conv_cycles(cc), .i_out_ready(rdy), .o_scan_start(st), .o_busy(bsy),
        .o_waiting(wt), .o_set_valid(sv), .o_set_data(sd), .o_fifo_ready(frd));
    tsb_host_model host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hold(hold),
        .i_set_valid(sv), .i_set_data(sd), .o_out_ready(rdy), .o_records(recs),
        .o_last_xy(lxy), .o_steps(stps));

    initial forever #25 i_clk = ~i_clk;

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic pulse(output int k);
        k = 0;
        do
        begin
            @(posedge i_clk);
            #1;
            k++;
        end while (st !== 1'b1 && k < 3000);
    endtask
    task automatic gap(input int e);
        pulse(n);
        pulse(n);
        chk(n == e, "start spacing");
        chk(wt === 1'b1 && bsy === 1'b0, "wait before next set");
        @(posedge i_clk);
        #1;
        chk(bsy === 1'b1 && wt === 1'b0, "busy during set");
    endtask
    task automatic quiet(input int c);
        int k;
        k = 0;
        repeat (c)
        begin
            @(posedge i_clk);
            #1;
            if (st !== 1'b0)
                k++;
        end
        chk(k == 0, "unexpected scan start");
    endtask
    task automatic go(input logic p, s, input logic [3:0] f, input logic [2:0] b,
        input logic [15:0] c);
        @(posedge i_clk);
        #5;
        pen = p;
        pen_scan_mode_select = s;
        fn = f;
        bd = b;
        cc = c;
    endtask
    task automatic scen(input logic [3:0] f, input logic [2:0] b, input logic [15:0] c,
        input int e);
        go(1'b1, 1'b1, f, b, c);
        gap(e);
        go(1'b0, 1'b1, f, b, c);
        quiet(20);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #(60000 * 50);
        miscompares++;
        print_verdict;
    end

    initial
    begin
        repeat (12) @(posedge i_clk);
        #5;
        i_rst_n = 1'b1;
        for (int i = 1; i < 8; i++)
            scen(tsb_pkg::FN_XYZ, 3'(i), 16'h0003, dly[i] * CYC + 1);
        chk(lxy === 1'b0, "xyz flag of record");
        $display("test delay codes done");
        scen(tsb_pkg::FN_XY, 3'h0, 16'h0005, 6);
        scen(tsb_pkg::FN_XYZ, 3'h1, 16'h0028, 41);
        go(1'b1, 1'b1, 4'h2, 3'h1, 16'h0003);
        quiet(50);
        $display("test self mode done");
        go(1'b1, 1'b0, tsb_pkg::FN_XY, 3'h2, 16'h0003);
        quiet(50);
        @(posedge i_clk);
        #5 fw = 1'b1;
        @(posedge i_clk);
        #5 fw = 1'b0;
        gap(21);
        chk(lxy === 1'b1, "xy flag of record");
        @(posedge i_clk);
        #5 stp = 1'b1;
        @(posedge i_clk);
        #5 stp = 1'b0;
        quiet(60);
        go(1'b0, 1'b0, tsb_pkg::FN_XYZ, 3'h0, 16'h0001);
        $display("test host mode done");
        r0 = recs;
        s0 = stps;
        hold = 1'b1;
        go(1'b1, 1'b1, tsb_pkg::FN_XYZ, 3'h0, 16'h0001);
        repeat (80) @(posedge i_clk);
        #1;
        chk(frd === 1'b0, "fifo should be full");
        quiet(20);
        hold = 1'b0;
        pulse(n);
        chk(n < 100, "restart after drain");
        go(1'b0, 1'b1, tsb_pkg::FN_XYZ, 3'h0, 16'h0001);
        repeat (100) @(posedge i_clk);
        #1;
        chk(frd === 1'b1 && recs - r0 == 17, "fifo drained");
        chk(stps - s0 >= 16, "record index steps");
        $display("test fifo done");
        print_verdict;
    end
endmodule
